// *** rtl/port_op_pkg.sv ***
// constants for the per-port operation control and link status registers
package port_op_pkg;
    localparam int NUM_PORTS        = 7;
    localparam int NUM_PHY_PORTS    = 5;
    localparam int ADDR_W           = 16;
    // byte address = port << 12 | offset, ports 1..7
    localparam logic [11:0] OFF_OP_CTRL  = 12'h020;
    localparam logic [11:0] OFF_LINK_ST  = 12'h030;
    localparam int PORT_MSB         = 15;
    localparam int PORT_LSB         = 12;
    // control field positions
    localparam int CTL_LOCAL_LB     = 7;
    localparam int CTL_REMOTE_LB    = 6;
    localparam int CTL_TAIL_TAG     = 2;
    localparam int CTL_QSPLIT_LSB   = 0;
    localparam logic [7:0] CTL_RW_MASK = 8'hC7;
    localparam logic [7:0] CTL_RESET   = 8'h00;
    // external interface control bit positions
    localparam int XC1_SPEED_1G     = 6;
    localparam int XC0_DUPLEX_HALF  = 6;
    localparam int XC0_TX_FC        = 5;
    localparam int XC0_SPEED_100    = 4;
    localparam int XC0_RX_FC        = 3;
    // phy advertisement flow control bits 11:10
    localparam int ADV_PAUSE        = 10;
    localparam int ADV_ASM_DIR      = 11;
    // status field positions
    localparam int ST_SPEED_LSB     = 3;
    localparam int ST_DUPLEX        = 2;
    localparam int ST_TX_FC         = 1;
    localparam int ST_RX_FC         = 0;
    // speed codes
    localparam logic [1:0] SPD_10   = 2'h0;
    localparam logic [1:0] SPD_100  = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    typedef enum logic [1:0] {
        QS_ONE  = 2'b00,
        QS_TWO  = 2'b01,
        QS_FOUR = 2'b10,
        QS_RSVD = 2'b11
    } qsplit_e;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// *** rtl/port_link_status_mux.sv ***
// builds the read-only link status byte of one port
`timescale 1ns/1ps
module port_link_status_mux #(
    parameter bit IS_PHY = 1'b1
) (
    input  wire logic [1:0] phy_speed,
    input  wire logic       phy_full_duplex,
    input  wire logic       phy_link_up,
    input  wire logic       phy_an_done,
    input  wire logic       phy_lp_pause,
    input  wire logic [1:0] phy_adv_fc,
    input  wire logic [7:0] xmii_ctrl0,
    input  wire logic [7:0] xmii_ctrl1,
    output logic      [7:0] status
);
    logic [1:0] spd;
    logic       dup;
    logic       txfc;
    logic       rxfc;
    logic       fc_ok;

    always_comb begin
        fc_ok = phy_link_up & phy_an_done & phy_lp_pause;
        if (IS_PHY) begin
            spd  = phy_speed;
            dup  = phy_full_duplex;
            txfc = fc_ok & phy_adv_fc[port_op_pkg::ADV_PAUSE - 10];
            rxfc = fc_ok & (phy_adv_fc[port_op_pkg::ADV_PAUSE - 10]
                   | phy_adv_fc[port_op_pkg::ADV_ASM_DIR - 10]);
        end else begin
            if (xmii_ctrl1[port_op_pkg::XC1_SPEED_1G]) begin
                spd = port_op_pkg::SPD_1000;
            end else if (xmii_ctrl0[port_op_pkg::XC0_SPEED_100]) begin
                spd = port_op_pkg::SPD_100;
            end else begin
                spd = port_op_pkg::SPD_10;
            end
            // control bit is a half-duplex select, status is full = 1
            dup  = ~xmii_ctrl0[port_op_pkg::XC0_DUPLEX_HALF];
            txfc = xmii_ctrl0[port_op_pkg::XC0_TX_FC];
            rxfc = xmii_ctrl0[port_op_pkg::XC0_RX_FC];
        end
        status = 8'h00;
        status[port_op_pkg::ST_SPEED_LSB +: 2] = spd;
        status[port_op_pkg::ST_DUPLEX]         = dup;
        status[port_op_pkg::ST_TX_FC]          = txfc;
        status[port_op_pkg::ST_RX_FC]          = rxfc;
    end
endmodule

// *** rtl/port_op_loop_path.sv ***
// per-port loopback steering of one data lane
`timescale 1ns/1ps
module port_op_loop_path #(
    parameter int DW = 8
) (
    input  wire logic          local_lb,
    input  wire logic          remote_lb,
    input  wire logic [DW-1:0] fab_tx_data,
    input  wire logic          fab_tx_en,
    input  wire logic [DW-1:0] line_rx_data,
    input  wire logic          line_rx_dv,
    output logic      [DW-1:0] fab_rx_data,
    output logic               fab_rx_dv,
    output logic      [DW-1:0] line_tx_data,
    output logic               line_tx_en
);
    // no elastic store in the remote path: clocks must match per frame
    always_comb begin
        if (local_lb) begin
            fab_rx_data = fab_tx_data;
            fab_rx_dv   = fab_tx_en;
        end else if (remote_lb) begin
            fab_rx_data = '0;
            fab_rx_dv   = 1'b0;
        end else begin
            fab_rx_data = line_rx_data;
            fab_rx_dv   = line_rx_dv;
        end
        if (remote_lb) begin
            line_tx_data = line_rx_data;
            line_tx_en   = line_rx_dv;
        end else if (local_lb) begin
            line_tx_data = '0;
            line_tx_en   = 1'b0;
        end else begin
            line_tx_data = fab_tx_data;
            line_tx_en   = fab_tx_en;
        end
    end
endmodule

// *** rtl/port_op_control_status_regs.sv ***
// per-port operation control and link status registers with AXI4-Lite access
// How it works
// - local loopback bit 7 turns fabric egress data back to the fabric inside the MAC.
// - remote loopback bit 6 turns line receive data back out the same port, off the fabric.
// - on phy ports the remote loop feeds the line receive pair to the line transmit pair.
// - on the external port the remote loop feeds the txd inputs out on the rxd outputs.
// - tail tag bit 2 makes the port the host port and enables tail tagging on it.
// - bits 1:0 pick one, two or four egress queues; code 11 is reserved.
// - non-phy speed status mirrors external control 1 bit 6 and control 0 bit 4.
// - phy speed status is the resolved speed: 00 10M, 01 100M, 10 1000M.
// - non-phy duplex status is the inverse of external control 0 bit 6.
// - phy duplex status is the resolved duplex, 1 full, 0 half.
// - non-phy tx flow control status mirrors external control 0 bit 5.
// - non-phy rx flow control status mirrors external control 0 bit 3.
// - phy flow control status needs advertisement, link up and negotiated pause.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module port_op_control_status_regs #(
    parameter int NP = 7,
    parameter int NPHY = 5,
    parameter int DW = 8
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             ce,
    input  wire logic [15:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [15:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic [2*NP-1:0]  phy_speed,
    input  wire logic [NP-1:0]    phy_full_duplex,
    input  wire logic [NP-1:0]    phy_link_up,
    input  wire logic [NP-1:0]    phy_an_done,
    input  wire logic [NP-1:0]    phy_lp_pause,
    input  wire logic [2*NP-1:0]  phy_adv_fc,
    input  wire logic [8*NP-1:0]  xmii_ctrl0,
    input  wire logic [8*NP-1:0]  xmii_ctrl1,
    input  wire logic [DW*NP-1:0] fab_tx_data,
    input  wire logic [NP-1:0]    fab_tx_en,
    input  wire logic [DW*NP-1:0] line_rx_data,
    input  wire logic [NP-1:0]    line_rx_dv,
    output logic [DW*NP-1:0]      fab_rx_data,
    output logic [NP-1:0]         fab_rx_dv,
    output logic [DW*NP-1:0]      line_tx_data,
    output logic [NP-1:0]         line_tx_en,
    output logic [NP-1:0]         tail_tag_en,
    output logic [2*NP-1:0]       egress_queues
);
    logic [7:0]       ctrl_r [NP];
    logic [7:0]       stat_c [NP];
    logic [7:0]       stat_r [NP];
    logic [DW*NP-1:0] fab_rx_c;
    logic [NP-1:0]    fab_dv_c;
    logic [DW*NP-1:0] line_tx_c;
    logic [NP-1:0]    line_en_c;
    logic [15:0]      awaddr_r;
    logic             aw_have_r;
    logic [31:0]      wdata_r;
    logic             wstrb0_r;
    logic             w_have_r;
    logic             wr_fire;
    logic             rd_fire;

    // port 1..NP in bits 15:12, returns index or NP when unmapped
    function automatic int unsigned port_index(input logic [15:0] a);
        int unsigned p;
        p = int'(a[port_op_pkg::PORT_MSB:port_op_pkg::PORT_LSB]);
        if (p < 1 || p > NP) begin
            return NP;
        end
        return p - 1;
    endfunction

    // queue field decode; reserved code falls back to a single queue
    function automatic logic [1:0] queue_count_code(input logic [1:0] f);
        unique case (port_op_pkg::qsplit_e'(f))
            port_op_pkg::QS_ONE:  return 2'h0;
            port_op_pkg::QS_TWO:  return 2'h1;
            port_op_pkg::QS_FOUR: return 2'h2;
            port_op_pkg::QS_RSVD: return 2'h0;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : gen_port
            port_link_status_mux #(
                .IS_PHY (g < NPHY)
            ) u_stat (
                .phy_speed       (phy_speed[2*g +: 2]),
                .phy_full_duplex (phy_full_duplex[g]),
                .phy_link_up     (phy_link_up[g]),
                .phy_an_done     (phy_an_done[g]),
                .phy_lp_pause    (phy_lp_pause[g]),
                .phy_adv_fc      (phy_adv_fc[2*g +: 2]),
                .xmii_ctrl0      (xmii_ctrl0[8*g +: 8]),
                .xmii_ctrl1      (xmii_ctrl1[8*g +: 8]),
                .status          (stat_c[g])
            );
            // phy ports: line rx pair to tx pair; xmii: txd in to rxd out
            port_op_loop_path #(
                .DW (DW)
            ) u_loop (
                .local_lb     (ctrl_r[g][port_op_pkg::CTL_LOCAL_LB]),
                .remote_lb    (ctrl_r[g][port_op_pkg::CTL_REMOTE_LB]),
                .fab_tx_data  (fab_tx_data[DW*g +: DW]),
                .fab_tx_en    (fab_tx_en[g]),
                .line_rx_data (line_rx_data[DW*g +: DW]),
                .line_rx_dv   (line_rx_dv[g]),
                .fab_rx_data  (fab_rx_c[DW*g +: DW]),
                .fab_rx_dv    (fab_dv_c[g]),
                .line_tx_data (line_tx_c[DW*g +: DW]),
                .line_tx_en   (line_en_c[g])
            );
        end
    endgenerate

    // registered loop outputs keep every top output on a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fab_rx_data  <= '0;
            fab_rx_dv    <= '0;
            line_tx_data <= '0;
            line_tx_en   <= '0;
        end else if (ce) begin
            fab_rx_data  <= fab_rx_c;
            fab_rx_dv    <= fab_dv_c;
            line_tx_data <= line_tx_c;
            line_tx_en   <= line_en_c;
        end
    end

    // status sampled each cycle so reads see a stable byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NP; i++) begin
                stat_r[i] <= 8'h00;
            end
        end else if (ce) begin
            for (int i = 0; i < NP; i++) begin
                stat_r[i] <= stat_c[i];
            end
        end
    end

    // write address and data captured in either order
    assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb0_r      <= 1'b0;
        end else if (ce) begin
            s_axi_awready <= ~aw_have_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_have_r & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_have_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= port_op_pkg::AXI_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                if (port_index(awaddr_r) < NP
                    && (awaddr_r[11:0] == port_op_pkg::OFF_OP_CTRL
                    || awaddr_r[11:0] == port_op_pkg::OFF_LINK_ST)) begin
                    s_axi_bresp <= port_op_pkg::AXI_OKAY;
                end else begin
                    s_axi_bresp <= port_op_pkg::AXI_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control store; status offset accepted but ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NP; i++) begin
                ctrl_r[i] <= port_op_pkg::CTL_RESET;
            end
        end else if (ce) begin
            if (wr_fire && wstrb0_r && port_index(awaddr_r) < NP
                && awaddr_r[11:0] == port_op_pkg::OFF_OP_CTRL) begin
                ctrl_r[port_index(awaddr_r)] <=
                    wdata_r[7:0] & port_op_pkg::CTL_RW_MASK;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tail_tag_en   <= '0;
            egress_queues <= '0;
        end else if (ce) begin
            for (int i = 0; i < NP; i++) begin
                tail_tag_en[i]       <= ctrl_r[i][port_op_pkg::CTL_TAIL_TAG];
                egress_queues[2*i +: 2] <=
                    queue_count_code(ctrl_r[i][port_op_pkg::CTL_QSPLIT_LSB +: 2]);
            end
        end
    end

    assign rd_fire = s_axi_arvalid & s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= port_op_pkg::AXI_OKAY;
        end else if (ce) begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= '0;
                s_axi_rresp  <= port_op_pkg::AXI_OKAY;
                if (port_index(s_axi_araddr) < NP
                    && s_axi_araddr[11:0] == port_op_pkg::OFF_OP_CTRL) begin
                    s_axi_rdata[7:0] <= ctrl_r[port_index(s_axi_araddr)];
                end else if (port_index(s_axi_araddr) < NP
                    && s_axi_araddr[11:0] == port_op_pkg::OFF_LINK_ST) begin
                    s_axi_rdata[7:0] <= stat_r[port_index(s_axi_araddr)];
                end else begin
                    s_axi_rresp <= port_op_pkg::AXI_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// *** bench/port_op_control_status_regs_checker.sv ***
// assertion checker for the port operation control and link status registers
`timescale 1ns/1ps
module port_op_control_status_regs_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [15:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [13:0] phy_speed,
    input wire logic [6:0]  phy_full_duplex,
    input wire logic [55:0] xmii_ctrl0,
    input wire logic [6:0]  fab_tx_en,
    input wire logic [6:0]  line_rx_dv,
    input wire logic [6:0]  fab_rx_dv,
    input wire logic [6:0]  line_tx_en,
    input wire logic [6:0]  tail_tag_en,
    input wire logic [13:0] egress_queues
);
    logic [15:0] rd_addr_r;
    // remember the read address so the answer can be tied to its port
    always_ff @(posedge aclk) begin
        if (!aresetn) rd_addr_r <= 16'h0000;
        else if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_wr_resp; s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_resp; s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read response late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
    a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
    property p_err_zero; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    property p_qs_rsvd; egress_queues[1:0] != 2'h3; endproperty
    a_qs_rsvd: assert property (p_qs_rsvd) else $error("reserved queue code out");
    property p_freeze; !ce |=> $stable(tail_tag_en) && $stable(egress_queues); endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
    property p_fab_cause; fab_rx_dv[5] |-> $past(fab_tx_en[5] | line_rx_dv[5]); endproperty
    a_fab_cause: assert property (p_fab_cause) else $error("fabric valid uncaused");
    property p_line_cause; line_tx_en[6] |-> $past(line_rx_dv[6] | fab_tx_en[6]); endproperty
    a_line_cause: assert property (p_line_cause) else $error("line valid uncaused");
    property p_ext_mirror; s_axi_rvalid && rd_addr_r == 16'h6030 |->
        s_axi_rdata[2:0] == {~xmii_ctrl0[46], xmii_ctrl0[45], xmii_ctrl0[43]}; endproperty
    a_ext_mirror: assert property (p_ext_mirror) else $error("mirror wrong");
    property p_phy_st; s_axi_rvalid && rd_addr_r == 16'h1030 |->
        s_axi_rdata[4:2] == {phy_speed[1:0], phy_full_duplex[0]}; endproperty
    a_phy_st: assert property (p_phy_st) else $error("phy status wrong");
endmodule
bind port_op_control_status_regs port_op_control_status_regs_checker u_chk (.*);

// *** bench/port_op_control_status_regs_test.sv ***
// self-checking bench for the port operation control and link status registers
`timescale 1ns/1ps
module port_op_control_status_regs_test;
    typedef struct {logic [7:0] d; logic [7:0] e; logic t; logic [1:0] q;} row_s;
    logic        aclk, aresetn, ce, stall;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [13:0] phy_speed, phy_adv_fc, egress_queues;
    logic [6:0]  phy_full_duplex, phy_link_up, phy_an_done, phy_lp_pause;
    logic [6:0]  fab_tx_en, line_rx_dv, fab_rx_dv, line_tx_en, tail_tag_en;
    logic [55:0] xmii_ctrl0, xmii_ctrl1, fab_tx_data, line_rx_data, fab_rx_data, line_tx_data;
    int          errors, check_count;
    // wdata, readback, tail tag, queue code; port 1 row holds reserved code 11
    row_s rows [7] = '{'{8'hFB, 8'hC3, 1'b0, 2'h0}, '{8'h04, 8'h04, 1'b1, 2'h0},
                       '{8'h01, 8'h01, 1'b0, 2'h1}, '{8'h02, 8'h02, 1'b0, 2'h2},
                       '{8'h38, 8'h00, 1'b0, 2'h0}, '{8'h80, 8'h80, 1'b0, 2'h0},
                       '{8'h40, 8'h40, 1'b0, 2'h0}};
    // speed, duplex, link, adv pair, expected status
    logic [13:0] ptab [3] = '{14'h2D17, 14'h1108, 14'h0C04};
    // ctrl0, ctrl1, expected status of port 6
    logic [23:0] etab [3] = '{24'h38000F, 24'h384017, 24'h400000};

    port_op_control_status_regs u_dut (.*);

    always #25 aclk = ~aclk;

    task automatic test_done;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_d(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t resp got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        s_axi_bready <= !stall;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
        if (!(s_axi_bvalid && s_axi_bready)) begin
            errors++;
            $display("[ERR] %0t write timeout got %h exp %h", $time, s_axi_bvalid, 1'b1);
            test_done();
        end
        r = s_axi_bresp;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !stall;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
        if (!(s_axi_rvalid && s_axi_rready)) begin
            errors++;
            $display("[ERR] %0t read timeout got %h exp %h", $time, s_axi_rvalid, 1'b1);
            test_done();
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic st(input logic [15:0] a, input logic [7:0] e);
        rd(a, rdat, resp);
        chk_r(resp, port_op_pkg::AXI_OKAY);
        chk_d(rdat, {24'h0, e});
    endtask

    // both lanes driven at once so precedence between the loops shows
    task automatic lb(input int i, input logic [17:0] e);
        {fab_tx_data[8*i +: 8], line_rx_data[8*i +: 8]} <= 16'hA53C;
        {fab_tx_en[i], line_rx_dv[i]} <= 2'b11;
        @(posedge aclk);
        #1;
        chk_d({14'h0, fab_rx_dv[i], line_tx_en[i], fab_rx_dv[i] ? fab_rx_data[8*i +: 8] : 8'h00,
               line_tx_en[i] ? line_tx_data[8*i +: 8] : 8'h00}, {14'h0, e});
        @(posedge aclk);
        {fab_tx_en[i], line_rx_dv[i]} <= 2'b00;
        @(posedge aclk);
    endtask

    initial begin
        aclk = 1'b0;
        {aresetn, stall, errors, check_count} <= '0;
        ce <= 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
        {phy_speed, phy_full_duplex, phy_link_up, phy_adv_fc} <= '0;
        {phy_an_done, phy_lp_pause} <= '1;
        {xmii_ctrl0, xmii_ctrl1, fab_tx_data, line_rx_data, fab_tx_en, line_rx_dv} <= '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 7; k++) begin
            wr({4'(k + 1), port_op_pkg::OFF_OP_CTRL}, rows[k].d, 4'hF, resp);
            chk_r(resp, port_op_pkg::AXI_OKAY);
            st({4'(k + 1), port_op_pkg::OFF_OP_CTRL}, rows[k].e);
            chk_d({31'h0, tail_tag_en[k]}, {31'h0, rows[k].t});
            chk_d({30'h0, egress_queues[2*k +: 2]}, {30'h0, rows[k].q});
        end
        $display("control rows done");
        lb(5, {2'b10, 8'hA5, 8'h00});
        lb(6, {2'b01, 8'h00, 8'h3C});
        lb(0, {2'b11, 8'hA5, 8'h3C});
        lb(1, {2'b11, 8'h3C, 8'hA5});
        $display("loopback done");
        for (int k = 0; k < 3; k++) begin
            {phy_speed[1:0], phy_full_duplex[0], phy_link_up[0], phy_adv_fc[1:0]} <= ptab[k][13:8];
            {xmii_ctrl0[47:40], xmii_ctrl1[47:40]} <= etab[k][23:8];
            repeat (2) @(posedge aclk);
            st(16'h1030, ptab[k][7:0]);
            st(16'h6030, etab[k][7:0]);
        end
        $display("status done");
        wr(16'h6030, 8'hFF, 4'hF, resp);
        chk_r(resp, port_op_pkg::AXI_OKAY);
        st(16'h6030, 8'h00);
        st(16'h6020, 8'h80);
        wr(16'h2020, 8'h00, 4'h0, resp);
        st(16'h2020, 8'h04);
        // blocking so the very next call already sees the slow ready
        stall = 1'b1;
        wr(16'h8020, 8'h01, 4'hF, resp);
        chk_r(resp, port_op_pkg::AXI_SLVERR);
        rd(16'h1024, rdat, resp);
        chk_r(resp, port_op_pkg::AXI_SLVERR);
        chk_d(rdat, 32'h0);
        stall = 1'b0;
        $display("refusals done");
        // frozen local loop must not pass the fabric strobe through
        fab_tx_en[5] <= 1'b1;
        ce <= 1'b0;
        repeat (3) @(posedge aclk);
        chk_d({31'h0, fab_rx_dv[5]}, 32'h0);
        ce <= 1'b1;
        fab_tx_en[5] <= 1'b0;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        st(16'h2020, 8'h00);
        chk_d({25'h0, tail_tag_en}, 32'h0);
        $display("reset done");
        test_done();
    end
endmodule
